// File: mwt_consts.vh
/*
  constants for the microstep wave table: register byte offsets, field positions,
  reset values and step figures.
  assumes inclusion by bare name from the wave table module only.
*/
// Contract
// - only a quarter wave is stored; symmetry builds the full 360 degree wave.
// - the 10-bit microstep counter indexes the fully expanded wave.
// - one incremental bit per entry, 256 bits in eight 32-bit writable registers.
// - each table step adds base slope, or base slope plus one for a set bit.
// - base slope per segment is -1, 0, 1 or 2; four segments per quarter.
// - three boundaries split the quarter; segment n uses slope n.
// - each microstep advance computes coil A and coil B into readable registers.
// - coil values restart from absolute start values when the counter passes zero.
// - first wave value at position zero comes from a programmable start field.
// - second wave start field holds the table value at 90 degrees (256 steps).
// - signed trim -128..+127 moves the second coil shift between 45 and 135 degrees.
// - after reset the table is a sine; the top word reads 0x00404222. Here words 0..6 reset to TABLE0_RST..TABLE6_RST, zero by default.
// - segment select resets to 0xFFFF8056, start values to 0x00F70000.
// - the table holds a usable sine from power up, before programming; with default parameters words 0..6 here reset to zero instead.
// - each step pulse moves the counter by 256/resolution in the chosen direction.
// - index output marks counter zero, the rising zero of the coil A wave.
`ifndef MWT_CONSTS_VH
`define MWT_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MWT_OFS_TABLE0 8'h00
`define MWT_OFS_SEG_SEL 8'h20
`define MWT_OFS_START 8'h24
`define MWT_OFS_CTRL 8'h28
`define MWT_OFS_COUNT 8'h2C
`define MWT_OFS_COIL 8'h30

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MWT_SEL_BND1_LSB 8
`define MWT_SEL_BND2_LSB 16
`define MWT_SEL_BND3_LSB 24
`define MWT_START_A_LSB 0
`define MWT_START_B_LSB 16
`define MWT_CTRL_RES_LSB 0
`define MWT_CTRL_TRIM_LSB 8
`define MWT_COIL_B_LSB 16

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MWT_TABLE7_RST 32'h0040_4222
`define MWT_TABLE_LOW_RST 32'h0000_0000
`define MWT_SEG_SEL_RST 32'hFFFF_8056
`define MWT_START_RST 32'h00F7_0000
`define MWT_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// step figures
// ----------------------------------------------------------------------------
`define MWT_QUARTER 10'h100
`define MWT_MAX_RES_SHIFT 4'h8

`endif

// File: mwt_wave_table.v
/*
  microstep wave table: quarter-wave incremental table expanded to a full wave,
  microstep counter driven by step and direction pins, coil A and coil B values,
  index output, and a classic wishbone register slave.
  assumes one 250 MHz clock, synchronous active-high reset, asynchronous step and
  direction pins, and a wishbone master on the same clock.
*/
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mwt_consts.vh"

module mwt_wave_table #(
  parameter [31:0] TABLE0_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE1_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE2_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE3_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE4_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE5_RST = `MWT_TABLE_LOW_RST,
  parameter [31:0] TABLE6_RST = `MWT_TABLE_LOW_RST
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire step_i,
  input wire dir_i,
  output wire [8:0] coil_a_current_o,
  output wire [8:0] coil_b_current_o,
  output wire [9:0] microstep_counter_o,
  output wire index_o,
  output wire busy_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WALK = 1'b1;

  reg [31:0] wave_bit_table_ff [0:7];
  reg [31:0] segment_select_ff;
  reg [31:0] wave_start_values_ff;
  reg [31:0] ctrl_ff;
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [2:0] step_sync_ff;
  reg [1:0] dir_sync_ff;
  reg [9:0] microstep_counter_ff;
  reg dirty_ff;
  reg state_ff;
  reg [7:0] walk_ff;
  reg [9:0] acc_ff;
  reg [8:0] idx_a_ff;
  reg [8:0] idx_b_ff;
  reg neg_a_ff;
  reg neg_b_ff;
  reg [9:0] mag_a_ff;
  reg [9:0] mag_b_ff;
  reg [8:0] coil_a_current_ff;
  reg [8:0] coil_b_current_ff;
  reg index_ff;
  integer i;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function [31:0] table_rst;
    input [2:0] n;
    begin
      case (n)
        3'd0: table_rst = TABLE0_RST;
        3'd1: table_rst = TABLE1_RST;
        3'd2: table_rst = TABLE2_RST;
        3'd3: table_rst = TABLE3_RST;
        3'd4: table_rst = TABLE4_RST;
        3'd5: table_rst = TABLE5_RST;
        3'd6: table_rst = TABLE6_RST;
        default: table_rst = `MWT_TABLE7_RST;
      endcase
    end
  endfunction

  function [31:0] byte_merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer b;
    begin
      byte_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          byte_merge[b*8 +: 8] = din[b*8 +: 8];
        end
      end
    end
  endfunction

  // quarter index for a full-wave position: mirrored in odd quadrants
  function [8:0] quarter_idx;
    input [9:0] pos;
    begin
      if (pos[8]) begin
        quarter_idx = 9'h100 - {1'b0, pos[7:0]};
      end else begin
        quarter_idx = {1'b0, pos[7:0]};
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------------
  wire [7:0] boundary_first = segment_select_ff[`MWT_SEL_BND1_LSB +: 8];
  wire [7:0] boundary_second = segment_select_ff[`MWT_SEL_BND2_LSB +: 8];
  wire [7:0] boundary_third = segment_select_ff[`MWT_SEL_BND3_LSB +: 8];
  wire [1:0] slope_seg0 = segment_select_ff[1:0];
  wire [1:0] slope_seg1 = segment_select_ff[3:2];
  wire [1:0] slope_seg2 = segment_select_ff[5:4];
  wire [1:0] slope_seg3 = segment_select_ff[7:6];
  wire [7:0] first_wave_start = wave_start_values_ff[`MWT_START_A_LSB +: 8];
  wire [7:0] second_wave_start = wave_start_values_ff[`MWT_START_B_LSB +: 8];
  wire [3:0] res_shift = ctrl_ff[`MWT_CTRL_RES_LSB +: 4];
  wire [7:0] phase_shift_trim = ctrl_ff[`MWT_CTRL_TRIM_LSB +: 8];

  // ----------------------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, dropped the next cycle
  // ----------------------------------------------------------------------------
  // writes land at the edge where the master samples ack, never earlier, so a
  // request withdrawn before its ack leaves every register untouched
  wire [7:0] wb_word = {wb_adr_i[7:2], 2'b00};
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wb_rd = wb_req & ~wb_we_i;
  wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  wire tab_hit = (wb_adr_i[7:5] == 3'b000);
  wire cfg_write = wb_wr & (tab_hit | (wb_word == `MWT_OFS_SEG_SEL) |
                   (wb_word == `MWT_OFS_START) | (wb_word == `MWT_OFS_CTRL));
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= wb_req;
      rdat_ff <= 32'h0000_0000;
      if (wb_rd) begin
        if (tab_hit) begin
          rdat_ff <= wave_bit_table_ff[wb_adr_i[4:2]];
        end else begin
          case (wb_word)
            `MWT_OFS_SEG_SEL: rdat_ff <= segment_select_ff;
            `MWT_OFS_START: rdat_ff <= wave_start_values_ff;
            `MWT_OFS_CTRL: rdat_ff <= ctrl_ff;
            `MWT_OFS_COUNT: rdat_ff <= {22'h00_0000, microstep_counter_ff};
            `MWT_OFS_COIL: rdat_ff <= {7'h00, coil_b_current_ff, 7'h00,
                                      coil_a_current_ff};
            default: rdat_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        wave_bit_table_ff[i] <= table_rst(i[2:0]);
      end
      segment_select_ff <= `MWT_SEG_SEL_RST;
      wave_start_values_ff <= `MWT_START_RST;
      ctrl_ff <= `MWT_CTRL_RST;
    end else if (ce_i && wb_wr) begin
      if (tab_hit) begin
        wave_bit_table_ff[wb_adr_i[4:2]] <=
          byte_merge(wave_bit_table_ff[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
      end else begin
        case (wb_word)
          `MWT_OFS_SEG_SEL: segment_select_ff <=
            byte_merge(segment_select_ff, wb_dat_i, wb_sel_i);
          `MWT_OFS_START: wave_start_values_ff <=
            byte_merge(wave_start_values_ff, wb_dat_i, wb_sel_i);
          `MWT_OFS_CTRL: ctrl_ff <= byte_merge(ctrl_ff, wb_dat_i, wb_sel_i);
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // step and direction pins, microstep counter
  // ----------------------------------------------------------------------------
  wire step_rise = step_sync_ff[1] & ~step_sync_ff[2];
  wire [3:0] eff_shift = (res_shift > `MWT_MAX_RES_SHIFT) ? `MWT_MAX_RES_SHIFT : res_shift;
  wire [9:0] step_amount = `MWT_QUARTER >> eff_shift;
  wire [9:0] nxt_microstep_counter = dir_sync_ff[1] ?
    microstep_counter_ff - step_amount : microstep_counter_ff + step_amount;

  always @(posedge clk_i) begin
    if (rst_i) begin
      step_sync_ff <= 3'b000;
      dir_sync_ff <= 2'b00;
      microstep_counter_ff <= 10'h000;
      index_ff <= 1'b1;
    end else if (ce_i) begin
      step_sync_ff <= {step_sync_ff[1:0], step_i};
      dir_sync_ff <= {dir_sync_ff[0], dir_i};
      if (step_rise) begin
        microstep_counter_ff <= nxt_microstep_counter;
        index_ff <= (nxt_microstep_counter == 10'h000);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // wave walk: rebuilds both coils from the start values on every change
  // ----------------------------------------------------------------------------
  // a full walk per update trades 257 cycles of latency for not having to track
  // partial sums across direction reversals and coarse step sizes
  wire [9:0] pos_a = microstep_counter_ff;
  wire [9:0] pos_b = microstep_counter_ff + `MWT_QUARTER +
                     {{2{phase_shift_trim[7]}}, phase_shift_trim};
  wire walk_bit = wave_bit_table_ff[walk_ff[7:5]][walk_ff[4:0]];
  reg [1:0] base_slope;

  always @* begin
    if (walk_ff < boundary_first) begin
      base_slope = slope_seg0;
    end else if (walk_ff < boundary_second) begin
      base_slope = slope_seg1;
    end else if (walk_ff < boundary_third) begin
      base_slope = slope_seg2;
    end else begin
      base_slope = slope_seg3;
    end
  end

  // code 0..3 means slope -1..2
  wire [9:0] nxt_acc = acc_ff + {8'h00, base_slope} + {9'h000, walk_bit} - 10'h001;
  wire [9:0] peak = {2'b00, second_wave_start};
  wire [9:0] fin_a = (walk_ff == idx_a_ff[7:0] && !idx_a_ff[8]) ? acc_ff : mag_a_ff;
  wire [9:0] fin_b = (walk_ff == idx_b_ff[7:0] && !idx_b_ff[8]) ? acc_ff : mag_b_ff;
  wire [9:0] sgn_a = neg_a_ff ? (~fin_a + 10'h001) : fin_a;
  wire [9:0] sgn_b = neg_b_ff ? (~fin_b + 10'h001) : fin_b;

  always @(posedge clk_i) begin
    if (rst_i) begin
      dirty_ff <= 1'b1;
      state_ff <= ST_IDLE;
      walk_ff <= 8'h00;
      acc_ff <= 10'h000;
      idx_a_ff <= 9'h000;
      idx_b_ff <= 9'h000;
      neg_a_ff <= 1'b0;
      neg_b_ff <= 1'b0;
      mag_a_ff <= 10'h000;
      mag_b_ff <= 10'h000;
      coil_a_current_ff <= 9'h000;
      coil_b_current_ff <= 9'h000;
    end else if (ce_i) begin
      // a change in the start cycle is kept: set beats clear
      dirty_ff <= (dirty_ff & ~(state_ff == ST_IDLE)) | step_rise | cfg_write;
      case (state_ff)
        ST_IDLE: begin
          if (dirty_ff) begin
            state_ff <= ST_WALK;
            walk_ff <= 8'h00;
            acc_ff <= {2'b00, first_wave_start};
            idx_a_ff <= quarter_idx(pos_a);
            idx_b_ff <= quarter_idx(pos_b);
            neg_a_ff <= pos_a[9];
            neg_b_ff <= pos_b[9];
            mag_a_ff <= peak;
            mag_b_ff <= peak;
          end
        end
        ST_WALK: begin
          mag_a_ff <= fin_a;
          mag_b_ff <= fin_b;
          acc_ff <= nxt_acc;
          walk_ff <= walk_ff + 8'h01;
          if (walk_ff == 8'hFF) begin
            state_ff <= ST_IDLE;
            coil_a_current_ff <= sgn_a[8:0];
            coil_b_current_ff <= sgn_b[8:0];
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign coil_a_current_o = coil_a_current_ff;
  assign coil_b_current_o = coil_b_current_ff;
  assign microstep_counter_o = microstep_counter_ff;
  assign index_o = index_ff;
  assign busy_o = (state_ff == ST_WALK) | dirty_ff;

endmodule

// File: mwt_wave_table_assertions.sv
/*
  port checker for the microstep wave table.
  assumes one clock, synchronous active-high reset, bound to every instance.
*/
`timescale 1ns/1ps
module mwt_wave_table_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [8:0] coil_a_current_o,
  input wire [8:0] coil_b_current_o,
  input wire [9:0] microstep_counter_o,
  input wire index_o,
  input wire busy_o
);
  // ---------------------------------------------------------------------------
  // step distance, up or down
  // ---------------------------------------------------------------------------
  reg [9:0] prev_ff;
  wire [9:0] up = microstep_counter_o - prev_ff;
  wire [9:0] dn = prev_ff - microstep_counter_o;
  wire up_ok = up <= 10'h100 && (up & (up - 10'h001)) == 10'h000;
  wire dn_ok = dn <= 10'h100 && (dn & (dn - 10'h001)) == 10'h000;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  always @(posedge clk_i) begin
    prev_ff <= microstep_counter_o;
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (req |=> wb_ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7:2] > 6'h0C
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_step_size: assert property (microstep_counter_o != prev_ff |-> up_ok || dn_ok)
    else $error("counter moved by an illegal amount");
  a_index_zero: assert property (index_o == (microstep_counter_o == 10'h000))
    else $error("index not tied to counter zero");
  a_count_busy: assert property ($changed(microstep_counter_o) |-> busy_o)
    else $error("counter moved without recompute");
  a_walk_bound: assert property ($rose(busy_o) |-> ##[1:600] !busy_o)
    else $error("recompute never finished");
  a_coil_hold: assert property (!busy_o && !$past(busy_o) && !$past(busy_o, 2)
    |-> $stable(coil_a_current_o) && $stable(coil_b_current_o))
    else $error("coil value moved while idle");
  a_ce_freeze: assert property (!ce_i |=> $stable(microstep_counter_o) && $stable(wb_ack_o))
    else $error("state moved with clock enable low");
endmodule

bind mwt_wave_table mwt_wave_table_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .coil_a_current_o(coil_a_current_o), .coil_b_current_o(coil_b_current_o),
  .microstep_counter_o(microstep_counter_o), .index_o(index_o), .busy_o(busy_o));

// File: mwt_wave_table_test.sv
/*
  self-checking bench for the microstep wave table: wishbone register tasks,
  step pulses, and a reference model of the expanded wave.
  assumes the design's checker is bound separately.
*/
`timescale 1ns/1ps
module mwt_wave_table_test;
  reg clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, step_i = 0, dir_i = 0;
  reg [7:0] adr = 0;
  reg [3:0] sel = 0;
  reg [31:0] wdat = 0, rdat, segs = 32'hFFFF_8056, sst = 32'h00F7_0000;
  reg [31:0] tbl [0:7];
  reg [9:0] cnt = 0, trm = 0, amt = 10'h100;
  wire [31:0] dat_o;
  wire ack, index_o, busy_o;
  wire [8:0] ca, cb;
  wire [9:0] msc;
  integer err_total = 0, samples_checked = 0, i;
  mwt_wave_table uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .step_i(step_i), .dir_i(dir_i),
    .coil_a_current_o(ca), .coil_b_current_o(cb), .microstep_counter_o(msc),
    .index_o(index_o), .busy_o(busy_o));
  initial forever #2 clk_i = ~clk_i;
  task end_sim;
    begin
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // ---------------------------------------------------------------------------
  // wave model: quarter sums, mirrored and negated by quadrant
  // ---------------------------------------------------------------------------
  function automatic integer qv(input integer n);
    integer k, v, sl;
    begin
      v = sst[7:0];
      for (k = 0; k < n; k++) begin
        sl = k < segs[15:8] ? segs[1:0] : k < segs[23:16] ? segs[3:2] :
          k < segs[31:24] ? segs[5:4] : segs[7:6];
        v = v + sl - 1 + tbl[k / 32][k % 32];
      end
      qv = n == 256 ? sst[23:16] : v;
    end
  endfunction
  function automatic [8:0] wave(input [9:0] p);
    integer v;
    begin
      v = p[8] ? qv(256 - p[7:0]) : qv(p[7:0]);
      if (p[9]) v = -v;
      wave = v[8:0];
    end
  endfunction
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
        err_total++;
        end_sim;
      end
      rdat = dat_o;
      cyc <= 0;
      stb <= 0;
      we <= 0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(0, a, 32'h0000_0000, 4'h0);
      chk($sformatf("register %h", a), rdat, e);
    end
  endtask
  task idle;
    integer n;
    begin
      n = 0;
      repeat (6) @(posedge clk_i);
      while (busy_o !== 1'b0 && n < 600) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 600) begin
        err_total++;
        end_sim;
      end
      repeat (2) @(posedge clk_i);
      chk("counter", msc, cnt);
      chk("index", index_o, cnt == 10'h000);
      chk("coil_a", ca, wave(cnt));
      chk("coil_b", cb, wave(cnt + 10'h100 + trm));
    end
  endtask
  task step(input d);
    begin
      @(posedge clk_i);
      dir_i <= d;
      @(posedge clk_i);
      step_i <= 1;
      repeat (3) @(posedge clk_i);
      step_i <= 0;
      cnt = d ? cnt - amt : cnt + amt;
      idle;
    end
  endtask
  initial begin
    for (i = 0; i < 7; i++) tbl[i] = 32'h0000_0000;
    tbl[7] = 32'h0040_4222;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h1C, 32'h0040_4222);
    rd(8'h20, 32'hFFFF_8056);
    rd(8'h24, 32'h00F7_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    idle;
    step(0);
    ce_i <= 0;
    step_i <= 1;
    repeat (4) @(posedge clk_i);
    step_i <= 0;
    ce_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("frozen counter", msc, cnt);
    bus(1, 8'h00, 32'hFFFF_FFFF, 4'h1);
    tbl[0] = 32'h0000_00FF;
    rd(8'h00, 32'h0000_00FF);
    segs = 32'hC080_401B;
    bus(1, 8'h20, segs, 4'hF);
    sst = 32'h00F6_0000;
    bus(1, 8'h24, sst, 4'hF);
    trm = 10'h3F4;
    amt = 10'h040;
    bus(1, 8'h28, 32'h0000_F402, 4'hF);
    rd(8'h28, 32'h0000_F402);
    bus(1, 8'h2C, 32'h0000_0155, 4'hF);
    rd(8'h2C, {22'h0, cnt});
    idle;
    rd(8'h30, {7'h0, wave(cnt + 10'h100 + trm), 7'h0, wave(cnt)});
    for (i = 0; i < 18; i++) step(0);
    for (i = 0; i < 7; i++) step(1);
    // resolution codes above eight clamp to the finest step of one
    bus(1, 8'h28, 32'h0000_F409, 4'hF);
    amt = 10'h001;
    step(1);
    // a second reset in mid-run must restore every default
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    tbl[0] = 32'h0000_0000;
    segs = 32'hFFFF_8056;
    sst = 32'h00F7_0000;
    trm = 10'h000;
    amt = 10'h100;
    cnt = 10'h000;
    rd(8'h00, 32'h0000_0000);
    rd(8'h20, 32'hFFFF_8056);
    rd(8'h28, 32'h0000_0000);
    idle;
    end_sim;
  end
endmodule
